// File: verilog/mcuic_top.sv
// interrupt controller: flags, enables, priority vectoring, wake-up, ahb-lite registers
// How it works
// - pin 1 edge field: 00 off, 01 rising, 10 falling, 11 both sets its flag
// - pin 0 edge field uses the same encoding to set the pin 0 flag
// - source events set their flag regardless of the enable bit
// - vector only when the source enable is one; flag stays otherwise
// - global enable at zero suppresses every vector
// - on accept push next pc and load the source vector
// - handler ends with return; controller pops saved pc back
// - servicing clears the global enable automatically
// - requests while blocked still set and hold their flags
// - no acknowledge while the stack is full
// - simultaneous requests resolved by fixed priority
// - a flag rising while sleep_in is high wakes the device; a flag already set does not
// - some sources own vectors, timer matches share multi-function vector
// - control 0 layout: conv flag 6, pin flags 5/4, enables 3..1, global 0
// - control 1 layout: tba, serial, eeprom, mf flags then enables
// - control 2: time base b flag bit 4, enable bit 0, rest zero
// - multi-function register: four match flags 7..4, enables 3..0
// - register bits read/write except the read-only status register, reset zero, unimplemented bits read zero
// - servicing a pin interrupt clears that pin flag
// - servicing the serial interrupt clears the serial flag
// - multi-function flag derives from the four timer match sources
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`default_nettype none
module mcuic_top #(
  parameter int PC_W = 12
) (
  input  wire logic            ref_clk_in,
  input  wire logic            rstn_in,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [11:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic [31:0]          hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  // external pins
  input  wire logic            ext_irq_pin0_in,
  input  wire logic            ext_irq_pin1_in,
  // internal source events, one-cycle pulses
  input  wire logic            converter_done_in,
  input  wire logic            serial_module_evt_in,
  input  wire logic            eeprom_evt_in,
  input  wire logic            timebase_a_evt_in,
  input  wire logic            timebase_b_evt_in,
  input  wire logic [3:0]      timer_match_in,   // ptm a, ptm p, ctm a, ctm p (3..0)
  // cpu core side
  input  wire logic            irq_slot_in,      // core may take an interrupt this cycle
  input  wire logic [PC_W-1:0] next_pc_in,
  input  wire logic            stack_full_in,
  input  wire logic            return_from_isr_in,
  input  wire logic [PC_W-1:0] popped_pc_in,
  input  wire logic            sleep_in,
  output logic                 irq_take_out,     // accept pulse
  output logic                 stack_push_out,
  output logic [PC_W-1:0]      push_pc_out,
  output logic                 pc_load_out,
  output logic [PC_W-1:0]      pc_load_val_out,
  output logic                 wake_out
);
  localparam int NUM_SRC_W = mcuic_pkg::NUM_SRC;
  logic [7:0] edge_sel_r;
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [7:0] mfi_r;
  logic       ph_write_r;
  logic [11:0] ph_addr_r;
  logic       pin0_edge;
  logic       pin1_edge;
  logic [NUM_SRC_W-1:0] req;
  logic [7:0] grant;
  logic       accept;
  logic [11:0] vec;
  logic       mf_evt;
  logic [7:0] flags_now;
  logic [7:0] flags_prev_r;
  logic [7:0] wdat;
  logic       wr_en;
  logic [7:0] rd_mux;

  // edge detectors for both pins
  mcuic_edge_det u_pin0 (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .pin_in     (ext_irq_pin0_in),
    .sel_in     (edge_sel_r[mcuic_pkg::EDGE_PIN0_LSB +: 2]),
    .edge_out   (pin0_edge)
  );
  mcuic_edge_det u_pin1 (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .pin_in     (ext_irq_pin1_in),
    .sel_in     (edge_sel_r[mcuic_pkg::EDGE_PIN1_LSB +: 2]),
    .edge_out   (pin1_edge)
  );

  // ahb address phase capture
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ph_write_r <= 1'b0;
      ph_addr_r  <= 12'h000;
    end else if (hready) begin
      ph_write_r <= hsel & htrans[1] & hwrite;
      ph_addr_r  <= haddr;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = ph_write_r;
  assign wdat      = hwdata[7:0];

  // multi-function match event: any enabled match sub-flag set
  assign mf_evt = |(mfi_r[mcuic_pkg::MF_FLAG_LSB +: 4] & mfi_r[mcuic_pkg::MF_EN_LSB +: 4]);

  // pending and enabled requests in priority order
  always_comb begin
    req = '0;
    req[mcuic_pkg::SRC_PIN0] = ctrl0_r[mcuic_pkg::C0_PIN0_F] & ctrl0_r[mcuic_pkg::C0_PIN0_E];
    req[mcuic_pkg::SRC_PIN1] = ctrl0_r[mcuic_pkg::C0_PIN1_F] & ctrl0_r[mcuic_pkg::C0_PIN1_E];
    req[mcuic_pkg::SRC_SER]  = ctrl1_r[mcuic_pkg::C1_SER_F] & ctrl1_r[mcuic_pkg::C1_SER_E];
    req[mcuic_pkg::SRC_EEP]  = ctrl1_r[mcuic_pkg::C1_EEP_F] & ctrl1_r[mcuic_pkg::C1_EEP_E];
    req[mcuic_pkg::SRC_MF]   = ctrl1_r[mcuic_pkg::C1_MF_F] & ctrl1_r[mcuic_pkg::C1_MF_E];
    req[mcuic_pkg::SRC_TBA]  = ctrl1_r[mcuic_pkg::C1_TBA_F] & ctrl1_r[mcuic_pkg::C1_TBA_E];
    req[mcuic_pkg::SRC_TBB]  = ctrl2_r[mcuic_pkg::C2_TBB_F] & ctrl2_r[mcuic_pkg::C2_TBB_E];
    req[mcuic_pkg::SRC_CONV] = ctrl0_r[mcuic_pkg::C0_CONV_F] & ctrl0_r[mcuic_pkg::C0_CONV_E];
  end

  // fixed priority, lowest index wins
  always_comb begin
    grant = 8'h00;
    for (int i = NUM_SRC_W - 1; i >= 0; i--) begin
      if (req[i]) begin
        grant = 8'h00;
        grant[i] = 1'b1;
      end
    end
  end

  // accept when globally enabled, stack not full, core slot open
  assign accept = ctrl0_r[mcuic_pkg::C0_GIE] & (|req) & ~stack_full_in & irq_slot_in;

  // vector lookup, timer matches share the mf vector
  always_comb begin
    vec = mcuic_pkg::VEC_CONV;
    if (grant[mcuic_pkg::SRC_PIN0]) vec = mcuic_pkg::VEC_PIN0;
    else if (grant[mcuic_pkg::SRC_PIN1]) vec = mcuic_pkg::VEC_PIN1;
    else if (grant[mcuic_pkg::SRC_SER]) vec = mcuic_pkg::VEC_SER;
    else if (grant[mcuic_pkg::SRC_EEP]) vec = mcuic_pkg::VEC_EEP;
    else if (grant[mcuic_pkg::SRC_MF]) vec = mcuic_pkg::VEC_MF;
    else if (grant[mcuic_pkg::SRC_TBA]) vec = mcuic_pkg::VEC_TBA;
    else if (grant[mcuic_pkg::SRC_TBB]) vec = mcuic_pkg::VEC_TBB;
  end

  assign irq_take_out = accept;

  // core-side outputs: push and jump on accept, restore on return
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stack_push_out  <= 1'b0;
      push_pc_out     <= '0;
      pc_load_out     <= 1'b0;
      pc_load_val_out <= '0;
    end else begin
      stack_push_out <= accept;
      pc_load_out    <= accept | return_from_isr_in;
      if (accept) begin
        push_pc_out     <= next_pc_in;
        pc_load_val_out <= vec[PC_W-1:0];
      end else if (return_from_isr_in) begin
        pc_load_val_out <= popped_pc_in;
      end
    end
  end

  // edge select register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      edge_sel_r <= mcuic_pkg::RST_REG;
    end else if (wr_en && ph_addr_r == mcuic_pkg::ADDR_EDGE_SEL) begin
      edge_sel_r <= {4'h0, wdat[3:0]};
    end
  end

  // control 0: write, then auto-clear on service, then events set (set wins)
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl0_r <= mcuic_pkg::RST_REG;
    end else begin
      logic [7:0] v;
      v = ctrl0_r;
      if (wr_en && ph_addr_r == mcuic_pkg::ADDR_CTRL0) v = {1'b0, wdat[6:0]};
      if (accept) begin
        v[mcuic_pkg::C0_GIE] = 1'b0;
        if (grant[mcuic_pkg::SRC_PIN0]) v[mcuic_pkg::C0_PIN0_F] = 1'b0;
        if (grant[mcuic_pkg::SRC_PIN1]) v[mcuic_pkg::C0_PIN1_F] = 1'b0;
        if (grant[mcuic_pkg::SRC_CONV]) v[mcuic_pkg::C0_CONV_F] = 1'b0;
      end
      if (pin0_edge) v[mcuic_pkg::C0_PIN0_F] = 1'b1;
      if (pin1_edge) v[mcuic_pkg::C0_PIN1_F] = 1'b1;
      if (converter_done_in) v[mcuic_pkg::C0_CONV_F] = 1'b1;
      ctrl0_r <= v;
    end
  end

  // control 1
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl1_r <= mcuic_pkg::RST_REG;
    end else begin
      logic [7:0] v;
      v = ctrl1_r;
      if (wr_en && ph_addr_r == mcuic_pkg::ADDR_CTRL1) v = wdat;
      if (accept) begin
        if (grant[mcuic_pkg::SRC_SER]) v[mcuic_pkg::C1_SER_F] = 1'b0;
        if (grant[mcuic_pkg::SRC_EEP]) v[mcuic_pkg::C1_EEP_F] = 1'b0;
        if (grant[mcuic_pkg::SRC_TBA]) v[mcuic_pkg::C1_TBA_F] = 1'b0;
        if (grant[mcuic_pkg::SRC_MF])  v[mcuic_pkg::C1_MF_F]  = 1'b0;
      end
      if (serial_module_evt_in) v[mcuic_pkg::C1_SER_F] = 1'b1;
      if (eeprom_evt_in)        v[mcuic_pkg::C1_EEP_F] = 1'b1;
      if (timebase_a_evt_in)    v[mcuic_pkg::C1_TBA_F] = 1'b1;
      if (mf_evt)               v[mcuic_pkg::C1_MF_F]  = 1'b1;
      ctrl1_r <= v;
    end
  end

  // control 2
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl2_r <= mcuic_pkg::RST_REG;
    end else begin
      logic [7:0] v;
      v = ctrl2_r;
      if (wr_en && ph_addr_r == mcuic_pkg::ADDR_CTRL2) begin
        v = 8'h00;
        v[mcuic_pkg::C2_TBB_F] = wdat[mcuic_pkg::C2_TBB_F];
        v[mcuic_pkg::C2_TBB_E] = wdat[mcuic_pkg::C2_TBB_E];
      end
      if (accept && grant[mcuic_pkg::SRC_TBB]) v[mcuic_pkg::C2_TBB_F] = 1'b0;
      if (timebase_b_evt_in) v[mcuic_pkg::C2_TBB_F] = 1'b1;
      ctrl2_r <= v;
    end
  end

  // multi-function register; sub-flags left for software to clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mfi_r <= mcuic_pkg::RST_REG;
    end else begin
      logic [7:0] v;
      v = mfi_r;
      if (wr_en && ph_addr_r == mcuic_pkg::ADDR_MFI) v = wdat;
      v[mcuic_pkg::MF_FLAG_LSB +: 4] = v[mcuic_pkg::MF_FLAG_LSB +: 4] | timer_match_in;
      mfi_r <= v;
    end
  end

  // the eight control-register flag bits gathered for wake detection
  assign flags_now = {ctrl0_r[mcuic_pkg::C0_CONV_F], ctrl0_r[mcuic_pkg::C0_PIN1_F],
                      ctrl0_r[mcuic_pkg::C0_PIN0_F], ctrl1_r[mcuic_pkg::C1_TBA_F],
                      ctrl1_r[mcuic_pkg::C1_SER_F], ctrl1_r[mcuic_pkg::C1_EEP_F],
                      ctrl1_r[mcuic_pkg::C1_MF_F], ctrl2_r[mcuic_pkg::C2_TBB_F]};

  // wake on any flag rising while asleep; a pre-set flag cannot rise
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_prev_r <= 8'h00;
      wake_out     <= 1'b0;
    end else begin
      flags_prev_r <= flags_now;
      wake_out     <= sleep_in & |(flags_now & ~flags_prev_r);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (ph_addr_r)
      mcuic_pkg::ADDR_EDGE_SEL: rd_mux = edge_sel_r;
      mcuic_pkg::ADDR_CTRL0:    rd_mux = ctrl0_r;
      mcuic_pkg::ADDR_CTRL1:    rd_mux = ctrl1_r;
      mcuic_pkg::ADDR_CTRL2:    rd_mux = ctrl2_r;
      mcuic_pkg::ADDR_MFI:      rd_mux = mfi_r;
      mcuic_pkg::ADDR_STATUS:   rd_mux = req;
      default:                  rd_mux = 8'h00;
    endcase
  end
  assign hrdata = {24'h000000, rd_mux};
endmodule // mcuic_top
`default_nettype wire

// File: include/mcuic_pkg.sv
// package: register map, field positions, vectors and priority for the interrupt controller
`default_nettype none
package mcuic_pkg;
  // register byte addresses on the bus
  localparam logic [11:0] ADDR_EDGE_SEL = 12'h000;
  localparam logic [11:0] ADDR_CTRL0    = 12'h004;
  localparam logic [11:0] ADDR_CTRL1    = 12'h008;
  localparam logic [11:0] ADDR_CTRL2    = 12'h00c;
  localparam logic [11:0] ADDR_MFI      = 12'h010;
  localparam logic [11:0] ADDR_STATUS   = 12'h014;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // edge select field positions
  localparam int EDGE_PIN0_LSB = 0;
  localparam int EDGE_PIN1_LSB = 2;
  // control 0 fields
  localparam int C0_CONV_F = 6;
  localparam int C0_PIN1_F = 5;
  localparam int C0_PIN0_F = 4;
  localparam int C0_CONV_E = 3;
  localparam int C0_PIN1_E = 2;
  localparam int C0_PIN0_E = 1;
  localparam int C0_GIE    = 0;
  // control 1 fields
  localparam int C1_TBA_F = 7;
  localparam int C1_SER_F = 6;
  localparam int C1_EEP_F = 5;
  localparam int C1_MF_F  = 4;
  localparam int C1_TBA_E = 3;
  localparam int C1_SER_E = 2;
  localparam int C1_EEP_E = 1;
  localparam int C1_MF_E  = 0;
  // control 2 fields
  localparam int C2_TBB_F = 4;
  localparam int C2_TBB_E = 0;
  // multi-function register: flags at 7..4, enables at 3..0
  localparam int MF_FLAG_LSB = 4;
  localparam int MF_EN_LSB   = 0;
  localparam int NUM_MF      = 4;
  // source indices, highest priority first
  localparam int SRC_PIN0 = 0;
  localparam int SRC_PIN1 = 1;
  localparam int SRC_SER  = 2;
  localparam int SRC_EEP  = 3;
  localparam int SRC_MF   = 4;
  localparam int SRC_TBA  = 5;
  localparam int SRC_TBB  = 6;
  localparam int SRC_CONV = 7;
  localparam int NUM_SRC  = 8;
  // vector addresses (implementation choice)
  localparam logic [11:0] VEC_PIN0 = 12'h004;
  localparam logic [11:0] VEC_PIN1 = 12'h008;
  localparam logic [11:0] VEC_SER  = 12'h00c;
  localparam logic [11:0] VEC_EEP  = 12'h010;
  localparam logic [11:0] VEC_MF   = 12'h014;
  localparam logic [11:0] VEC_TBA  = 12'h018;
  localparam logic [11:0] VEC_TBB  = 12'h01c;
  localparam logic [11:0] VEC_CONV = 12'h020;
endpackage : mcuic_pkg
`default_nettype wire

// File: verilog/mcuic_edge_det.sv
// pin synchroniser and selectable edge detector for one external request pin
`default_nettype none
module mcuic_edge_det (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       pin_in,
  input  wire logic [1:0] sel_in,
  output logic            edge_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  // edge decode per select code
  always_comb begin
    edge_out = 1'b0;
    if (s2_r == s3_r && s3_r != level_r) begin
      case (sel_in)
        mcuic_pkg::EDGE_NONE: edge_out = 1'b0;
        mcuic_pkg::EDGE_RISE: edge_out = s3_r;
        mcuic_pkg::EDGE_FALL: edge_out = ~s3_r;
        mcuic_pkg::EDGE_BOTH: edge_out = 1'b1;
        default:              edge_out = 1'b0;
      endcase
    end
  end
endmodule // mcuic_edge_det
`default_nettype wire

// File: tb/mcuic_sva.sv
// checker: core handshake and bus response properties of the interrupt controller
`default_nettype none
module mcuic_sva #(
  parameter int PC_W = 12
) (
  input wire logic            ref_clk_in,
  input wire logic            rstn_in,
  input wire logic            hreadyout,
  input wire logic            hresp,
  input wire logic            irq_slot_in,
  input wire logic [PC_W-1:0] next_pc_in,
  input wire logic            stack_full_in,
  input wire logic            return_from_isr_in,
  input wire logic [PC_W-1:0] popped_pc_in,
  input wire logic            sleep_in,
  input wire logic            irq_take_out,
  input wire logic            stack_push_out,
  input wire logic [PC_W-1:0] push_pc_out,
  input wire logic            pc_load_out,
  input wire logic [PC_W-1:0] pc_load_val_out,
  input wire logic            wake_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // accept pulse and the entry step that follows it
  sequence s_take;
    irq_take_out;
  endsequence
  sequence s_enter;
    stack_push_out && pc_load_out;
  endsequence
  take_gate_a: assert property (irq_take_out |-> irq_slot_in && !stack_full_in)
    else $error("accept while stack full or no slot");
  push_pc_a: assert property (s_take |=> s_enter ##0 (push_pc_out == $past(next_pc_in)))
    else $error("entry push missing or wrong pc");
  vec_range_a: assert property (s_take |=> (pc_load_val_out[1:0] == 2'h0) &&
    (pc_load_val_out inside {[mcuic_pkg::VEC_PIN0:mcuic_pkg::VEC_CONV]}))
    else $error("loaded value is no vector");
  gie_drop_a: assert property (s_take |=> !irq_take_out)
    else $error("second accept without global enable");
  ret_pop_a: assert property (return_from_isr_in |=> pc_load_out && !stack_push_out &&
    (pc_load_val_out == $past(popped_pc_in)))
    else $error("return did not restore pc");
  push_cause_a: assert property (stack_push_out |-> $past(irq_take_out))
    else $error("push without accept");
  load_cause_a: assert property (pc_load_out |-> $past(irq_take_out || return_from_isr_in))
    else $error("pc load without cause");
  wake_cause_a: assert property (wake_out |-> $past(sleep_in))
    else $error("wake outside sleep");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
endmodule // mcuic_sva
bind mcuic_top mcuic_sva #(.PC_W(PC_W)) u_sva (.ref_clk_in, .rstn_in, .hreadyout, .hresp,
  .irq_slot_in, .next_pc_in, .stack_full_in, .return_from_isr_in, .popped_pc_in, .sleep_in,
  .irq_take_out, .stack_push_out, .push_pc_out, .pc_load_out, .pc_load_val_out, .wake_out);
`default_nettype wire

// File: tb/mcuic_core_model.sv
// cpu core stand-in: program counter, return stack and return requests
`default_nettype none
module mcuic_core_model #(
  parameter int DEPTH = 2
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        push_in,
  input  wire logic [11:0] push_pc_in,
  input  wire logic        ret_req_in,
  output logic             slot_out,
  output logic [11:0]      next_pc_out,
  output logic             full_out,
  output logic             ret_out,
  output logic [11:0]      pop_pc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] stk_r [DEPTH];
  int          sp_r;
  // pc advances each cycle, pushes on accept, pops on return
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      next_pc_out <= 12'h100;
      sp_r        <= 0;
      ret_out     <= 1'b0;
      pop_pc_out  <= 12'h000;
    end else begin
      next_pc_out <= next_pc_out + 12'h001;
      ret_out     <= 1'b0;
      pop_pc_out  <= ~pop_pc_out; // stale value is not held
      if (push_in) begin
        stk_r[sp_r] <= push_pc_in;
        sp_r        <= sp_r + 1;
      end else if (ret_req_in && sp_r > 0) begin
        ret_out    <= 1'b1;
        pop_pc_out <= stk_r[sp_r-1];
        sp_r       <= sp_r - 1;
      end
    end
  end
  // full stack blocks accepts; every fourth cycle is no slot
  assign full_out = (sp_r == DEPTH);
  assign slot_out = (next_pc_out[1:0] != 2'h3);
endmodule // mcuic_core_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench: registers, edges, priority service, nesting, stack full, wake
`default_nettype none
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_in, rstn_in, hsel, hwrite, hreadyout, hresp, ret_req, sleep_in, woke;
  logic        irq_slot_in, stack_full_in, return_from_isr_in, irq_take_out;
  logic        stack_push_out, pc_load_out, wake_out;
  logic [11:0] haddr, next_pc_in, popped_pc_in, push_pc_out, pc_load_val_out, lval;
  logic [1:0]  htrans, pins;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [4:0]  evt; // converter, serial, eeprom, time base a, time base b
  logic [3:0]  tmatch;
  logic [7:0]  wv;
  logic [11:0] exp_q[$];
  int          n_errors, checks_done, seed;
  localparam logic [11:0] ADR [6] = '{mcuic_pkg::ADDR_EDGE_SEL, mcuic_pkg::ADDR_CTRL0,
    mcuic_pkg::ADDR_CTRL1, mcuic_pkg::ADDR_CTRL2, mcuic_pkg::ADDR_MFI, 12'h020};
  localparam logic [7:0]  MSK [6] = '{8'h0f, 8'h7e, 8'hff, 8'h11, 8'hff, 8'h00};
  localparam logic [11:0] VEC [8] = '{mcuic_pkg::VEC_PIN0, mcuic_pkg::VEC_PIN1,
    mcuic_pkg::VEC_SER, mcuic_pkg::VEC_EEP, mcuic_pkg::VEC_MF, mcuic_pkg::VEC_TBA,
    mcuic_pkg::VEC_TBB, mcuic_pkg::VEC_CONV};
  mcuic_top uut (.ref_clk_in, .rstn_in, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_irq_pin0_in(pins[0]),
    .ext_irq_pin1_in(pins[1]), .converter_done_in(evt[0]), .serial_module_evt_in(evt[1]),
    .eeprom_evt_in(evt[2]), .timebase_a_evt_in(evt[3]), .timebase_b_evt_in(evt[4]),
    .timer_match_in(tmatch), .irq_slot_in, .next_pc_in, .stack_full_in, .return_from_isr_in,
    .popped_pc_in, .sleep_in, .irq_take_out, .stack_push_out, .push_pc_out, .pc_load_out,
    .pc_load_val_out, .wake_out);
  mcuic_core_model u_core (.clk_in(ref_clk_in), .rstn_in, .push_in(stack_push_out),
    .push_pc_in(push_pc_out), .ret_req_in(ret_req), .slot_out(irq_slot_in),
    .next_pc_out(next_pc_in), .full_out(stack_full_in), .ret_out(return_from_isr_in),
    .pop_pc_out(popped_pc_in));
  // clock generation
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  // single ahb-lite transfer, waits for ready in both phases
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge ref_clk_in);
    while (hreadyout !== 1'b1) @(posedge ref_clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge ref_clk_in);
    while (hreadyout !== 1'b1) @(posedge ref_clk_in);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK("read data", {24'h0, e}, rd)
  endtask
  task automatic rmw(input logic [11:0] a, input logic [7:0] s, input logic [7:0] c);
    xfer(1'b0, a, 8'h00);
    xfer(1'b1, a, (rd[7:0] | s) & ~c);
  endtask
  task automatic pulse(input logic [4:0] e, input logic [3:0] t);
    @(posedge ref_clk_in);
    evt <= e;
    tmatch <= t;
    @(posedge ref_clk_in);
    evt <= 5'h00;
    tmatch <= 4'h0;
    repeat (6) @(posedge ref_clk_in);
  endtask
  task automatic wait_q();
    for (int i = 0; i < 60 && exp_q.size() > 0; i++) @(posedge ref_clk_in);
    `CHK("accept count", 0, exp_q.size())
  endtask
  task automatic ret_once();
    @(posedge ref_clk_in);
    ret_req <= 1'b1;
    @(posedge ref_clk_in);
    ret_req <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // every entry is checked against the oldest expected vector
  always @(negedge ref_clk_in) begin
    if (wake_out === 1'b1) woke = 1'b1;
    if (stack_push_out === 1'b1) begin
      lval = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hxxx;
      `CHK("vector", lval, pc_load_val_out)
    end
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge ref_clk_in);
    n_errors++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {rstn_in, hsel, hwrite, ret_req, sleep_in, woke, pins, evt, tmatch} = '0;
    {haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    seed = 32'h19353eb5;
    repeat (20) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(ADR[i], 8'h00);
    for (int i = 0; i < 6; i++) begin
      wv = 8'($random(seed));
      if (i == 1) wv[0] = 1'b0;
      xfer(1'b1, ADR[i], wv);
      rdchk(ADR[i], wv & MSK[i]);
    end
    for (int i = 5; i >= 0; i--) xfer(1'b1, ADR[i], 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        xfer(1'b1, ADR[0], 8'(c << (2 * p)));
        pins[p] <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        rdchk(ADR[1], 8'((c & 1) << (4 + p)));
        xfer(1'b1, ADR[1], 8'h00);
        pins[p] <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        rdchk(ADR[1], 8'((c >> 1) << (4 + p)));
        xfer(1'b1, ADR[1], 8'h00);
      end
    end
    xfer(1'b1, ADR[1], 8'h01);
    sleep_in <= 1'b1;
    woke = 1'b0;
    pulse(5'h01, 4'h0);
    `CHK("wake", 1'b1, woke)
    rdchk(ADR[1], 8'h41);
    woke = 1'b0;
    pulse(5'h01, 4'h0);
    `CHK("wake", 1'b0, woke)
    sleep_in <= 1'b0;
    xfer(1'b1, ADR[1], 8'h00);
    xfer(1'b1, ADR[2], 8'h0f);
    xfer(1'b1, ADR[3], 8'h01);
    xfer(1'b1, ADR[4], 8'h01);
    xfer(1'b1, ADR[0], 8'h05);
    xfer(1'b1, ADR[1], 8'h0e);
    pins <= 2'h3;
    pulse(5'h1f, 4'h1);
    rdchk(ADR[1], 8'h7e);
    rdchk(ADR[2], 8'hff);
    rdchk(mcuic_pkg::ADDR_STATUS, 8'hff);
    for (int i = 0; i < 8; i++) begin
      exp_q.push_back(VEC[i]);
      rmw(ADR[1], 8'h01, 8'h00);
      wait_q();
      if (i == 4) begin
        rdchk(ADR[4], 8'h11);
        xfer(1'b1, ADR[4], 8'h00);
        rmw(ADR[2], 8'h00, 8'h10);
      end
      ret_once();
    end
    rdchk(mcuic_pkg::ADDR_STATUS, 8'h00);
    rdchk(ADR[1], 8'h0e);
    exp_q.push_back(mcuic_pkg::VEC_EEP);
    exp_q.push_back(mcuic_pkg::VEC_TBA);
    pulse(5'h0c, 4'h0);
    rmw(ADR[1], 8'h01, 8'h00);
    repeat (8) @(posedge ref_clk_in);
    rmw(ADR[1], 8'h01, 8'h00);
    wait_q();
    pulse(5'h02, 4'h0);
    rmw(ADR[1], 8'h01, 8'h00);
    repeat (12) @(posedge ref_clk_in);
    rdchk(mcuic_pkg::ADDR_STATUS, 8'h04);
    rmw(ADR[1], 8'h00, 8'h01);
    exp_q.push_back(mcuic_pkg::VEC_SER);
    ret_once();
    rmw(ADR[1], 8'h01, 8'h00);
    wait_q();
    repeat (2) ret_once();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
